// ==== ccp_pkg.sv ====
// Constants, register map and field layouts of the compare-trigger/PWM unit
package ccp_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_UNIT_CTRL   = 8'h00;
	localparam logic [7:0] OFF_DUTY_LOW    = 8'h04;
	localparam logic [7:0] OFF_DUTY_ACTIVE = 8'h08;
	localparam logic [7:0] OFF_PERIOD      = 8'h0C;
	localparam logic [7:0] OFF_PT_CTRL     = 8'h10;
	localparam logic [7:0] OFF_PT_COUNT    = 8'h14;
	localparam logic [7:0] OFF_FLAGS       = 8'h18;
	localparam logic [7:0] OFF_REF_TIMER   = 8'h1C;
	localparam logic [7:0] OFF_REF_CTRL    = 8'h20;

	// Mode select codes
	localparam logic [3:0] MODE_OFF  = 4'h0;
	localparam logic [3:0] MODE_TRIG = 4'hB;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;

	// Flag bit positions
	localparam int FLG_PERIOD = 0;
	localparam int FLG_REFOVF = 1;
	localparam int FLG_MATCH  = 2;
	localparam int FLG_W      = 3;

	// Reset values
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [7:0]  RST_PERIOD = 8'hFF;
	localparam logic [15:0] RST_REF    = 16'h0000;

	// Oscillator periods per period timer count at prescale 1:1
	localparam logic [9:0] OSC_PER_COUNT = 10'h004;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] dutyLsb;
		logic [3:0] mode;
	} unit_ctrl_t;

	typedef struct packed {
		logic [3:0] postscale;
		logic       run;
		logic [1:0] prescale;
	} pt_ctrl_t;

	// Prescale code to shift: 1:1, 1:4, 1:16, 1:64
	function automatic logic [2:0] psShift(input logic [1:0] code);
		return {code, 1'b0};
	endfunction

	// Last prescaler count before the period timer steps
	function automatic logic [7:0] subMax(input logic [1:0] code);
		logic [9:0] span;
		span = OSC_PER_COUNT << psShift(code);
		return 8'(span - 10'h001);
	endfunction

endpackage

// ==== period_time_base.sv ====
// Period timer with prescaler and 10-bit PWM time base
`timescale 1ns/1ps
module period_time_base
	import ccp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstN,
	// Control
	input  wire logic       run,
	input  wire logic [1:0] prescale,
	input  wire logic [7:0] period,
	input  wire logic       load,
	input  wire logic [7:0] loadVal,
	// Status
	output logic      [7:0] count,
	output logic      [9:0] timeBase,
	output logic            periodEnd
);

	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [7:0] sub_q;
	logic [7:0] sub_d;
	logic       subAtMax;
	logic [7:0] countStep;
	logic [7:0] subStep;

	always_comb begin
		// Greater-or-equal keeps a prescale change from stretching a count
		subAtMax  = sub_q >= subMax(prescale);
		periodEnd = run & subAtMax & (count_q == period);
		// Value after one counting step, independent of a software load
		if (subAtMax) begin
			subStep   = RST_BYTE;
			countStep = periodEnd ? RST_BYTE : count_q + 8'h01;
		end else begin
			subStep   = sub_q + 8'h01;
			countStep = count_q;
		end
		count_d = count_q;
		sub_d   = sub_q;
		if (load) begin
			count_d = loadVal;
			sub_d   = RST_BYTE;
		end else if (run) begin
			count_d = countStep;
			sub_d   = subStep;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count_q <= RST_BYTE;
			sub_q   <= RST_BYTE;
		end else begin
			count_q <= count_d;
			sub_q   <= sub_d;
		end
	end

	assign count    = count_q;
	// Time base as it stands after this edge, so the pin clears on time
	assign timeBase = {countStep, 2'(subStep >> psShift(prescale))};

endmodule

// ==== ccp_compare_trigger_and_pwm.sv ====
// Compare auto-conversion trigger and standard PWM unit with AXI4-Lite access
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module ccp_compare_trigger_and_pwm
	import ccp_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// AXI4-Lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	// AXI4-Lite read data
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// System
	input  wire logic              sleep,
	input  wire logic              refTick,
	input  wire logic              adcEnable,
	// Trigger and pin
	output logic                   adcStart,
	output logic                   eventPinOut,
	output logic                   eventPinDrive
);

	// Reset synchroniser
	logic rstMeta_q;
	logic rstN_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_q <= 1'b0;
			rstN_q    <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN_q    <= rstMeta_q;
		end
	end

	// Register state
	unit_ctrl_t       ctrl_q;
	unit_ctrl_t       ctrl_d;
	logic [7:0]       dutyLow_q;
	logic [7:0]       dutyLow_d;
	logic [7:0]       dutyActive_q;
	logic [7:0]       dutyActive_d;
	logic [1:0]       dutyLatch_q;
	logic [1:0]       dutyLatch_d;
	logic [7:0]       period_q;
	logic [7:0]       period_d;
	pt_ctrl_t         ptCtrl_q;
	pt_ctrl_t         ptCtrl_d;
	logic             refRun_q;
	logic             refRun_d;
	logic [15:0]      refCount_q;
	logic [15:0]      refCount_d;
	logic [FLG_W-1:0] flags_q;
	logic [FLG_W-1:0] flags_d;
	logic             matchSeen_q;
	logic             matchSeen_d;
	logic             pin_q;
	logic             pin_d;

	// Bus state
	logic             bvalid_q;
	logic             bvalid_d;
	logic [1:0]       bresp_q;
	logic [1:0]       bresp_d;
	logic             rvalid_q;
	logic             rvalid_d;
	logic [1:0]       rresp_q;
	logic [1:0]       rresp_d;
	logic [31:0]      rdata_q;
	logic [31:0]      rdata_d;

	// Decode helpers
	logic [7:0]       wAddr;
	logic [7:0]       rAddr;
	logic             wrEn;
	logic             rdEn;
	logic [31:0]      rdMux;

	// Datapath
	logic             pwmMode;
	logic             trigMode;
	logic             ptRun;
	logic             ptLoad;
	logic [7:0]       ptCount;
	logic [9:0]       timeBase;
	logic             periodEnd;
	logic [9:0]       dutyFull;
	logic [9:0]       dutyNext;
	logic [15:0]      compareVal;
	logic             refMatch;
	logic             refStep;
	logic             refReset;
	logic             newMatch;

	function automatic logic mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		unique case (a)
			OFF_UNIT_CTRL, OFF_DUTY_LOW, OFF_DUTY_ACTIVE, OFF_PERIOD,
			OFF_PT_CTRL, OFF_PT_COUNT, OFF_FLAGS, OFF_REF_TIMER,
			OFF_REF_CTRL: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	assign wAddr = 8'(awaddr);
	assign rAddr = 8'(araddr);

	// Address and data are taken together, one write outstanding at a time
	assign awready = awvalid & wvalid & ~bvalid_q;
	assign wready  = awvalid & wvalid & ~bvalid_q;
	assign wrEn    = awvalid & wvalid & ~bvalid_q;
	assign arready = ~rvalid_q;
	assign rdEn    = arvalid & ~rvalid_q;

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp  = rresp_q;
	assign rdata  = rdata_q;

	// Mode decode
	assign pwmMode  = ctrl_q.mode[3:2] == MODE_PWM_TOP;
	assign trigMode = ctrl_q.mode == MODE_TRIG;

	// Sleep stops every time base
	assign ptRun   = ptCtrl_q.run & ~sleep;
	assign refStep = refTick & refRun_q & ~sleep;

	// Compare pair shares the duty registers outside PWM mode
	assign compareVal = {dutyActive_q, dutyLow_q};
	assign refMatch   = refCount_q == compareVal;
	assign newMatch   = trigMode & refMatch & ~matchSeen_q & ~sleep;

	// Reset only on a later timer edge while the match still holds
	assign refReset = refStep & trigMode & refMatch;

	assign adcStart = newMatch & adcEnable;

	assign dutyFull = {dutyActive_q, dutyLatch_q};
	assign dutyNext = {dutyLow_q, ctrl_q.dutyLsb};

	// Pin is driven only in PWM mode
	assign eventPinDrive = pwmMode;
	assign eventPinOut   = pin_q;

	// Postscale field is not routed to the time base
	period_time_base u_time_base (
		.clk       (clk),
		.rstN      (rstN_q),
		.run       (ptRun),
		.prescale  (ptCtrl_q.prescale),
		.period    (period_q),
		.load      (ptLoad),
		.loadVal   (wdata[7:0]),
		.count     (ptCount),
		.timeBase  (timeBase),
		.periodEnd (periodEnd)
	);

	// Read multiplexer
	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (rAddr)
			OFF_UNIT_CTRL:   rdMux = {26'h0, ctrl_q};
			OFF_DUTY_LOW:    rdMux = {24'h0, dutyLow_q};
			OFF_DUTY_ACTIVE: rdMux = {24'h0, dutyActive_q};
			OFF_PERIOD:      rdMux = {24'h0, period_q};
			OFF_PT_CTRL:     rdMux = {25'h0, ptCtrl_q};
			OFF_PT_COUNT:    rdMux = {24'h0, ptCount};
			OFF_FLAGS:       rdMux = {29'h0, flags_q};
			OFF_REF_TIMER:   rdMux = {16'h0, refCount_q};
			OFF_REF_CTRL:    rdMux = {31'h0, refRun_q};
			default:         rdMux = 32'h0000_0000;
		endcase
	end

	// Bus handshake next state
	always_comb begin
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (wrEn) begin
			bvalid_d = 1'b1;
			bresp_d  = mapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (rdEn) begin
			rvalid_d = 1'b1;
			rresp_d  = mapped(rAddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_d  = rdMux;
		end
	end

	// Register and unit next state
	always_comb begin
		ctrl_d       = ctrl_q;
		dutyLow_d    = dutyLow_q;
		dutyActive_d = dutyActive_q;
		dutyLatch_d  = dutyLatch_q;
		period_d     = period_q;
		ptCtrl_d     = ptCtrl_q;
		refRun_d     = refRun_q;
		refCount_d   = refCount_q;
		flags_d      = flags_q;
		matchSeen_d  = matchSeen_q;
		pin_d        = pin_q;
		ptLoad       = 1'b0;

		// Reference timer counting and trigger reset
		if (refReset) begin
			refCount_d = RST_REF;
		end else if (refStep) begin
			refCount_d = refCount_q + 16'h0001;
			if (refCount_q == 16'hFFFF) begin
				flags_d[FLG_REFOVF] = 1'b1;
			end
		end
		if (!sleep) begin
			matchSeen_d = trigMode & refMatch;
		end

		// PWM waveform
		if (!pwmMode) begin
			pin_d = 1'b0;
		end else if (periodEnd) begin
			dutyActive_d = dutyLow_q;
			dutyLatch_d  = ctrl_q.dutyLsb;
			pin_d        = dutyNext != 10'h000;
		end else if (ptRun && timeBase == dutyFull) begin
			// Duty beyond the period never matches, so the pin holds
			pin_d = 1'b0;
		end

		// Software writes; byte lane 0 carries every 8-bit field
		if (wrEn && wstrb[0]) begin
			unique case (wAddr)
				OFF_UNIT_CTRL: ctrl_d = unit_ctrl_t'(wdata[5:0]);
				OFF_DUTY_LOW:  dutyLow_d = wdata[7:0];
				OFF_DUTY_ACTIVE: begin
					if (!pwmMode) begin
						dutyActive_d = wdata[7:0];
					end
				end
				OFF_PERIOD:    period_d = wdata[7:0];
				OFF_PT_CTRL:   ptCtrl_d = pt_ctrl_t'(wdata[6:0]);
				OFF_PT_COUNT:  ptLoad = 1'b1;
				OFF_FLAGS:     flags_d = flags_d & ~wdata[FLG_W-1:0];
				OFF_REF_TIMER: refCount_d[7:0] = wdata[7:0];
				OFF_REF_CTRL:  refRun_d = wdata[0];
				default: begin
				end
			endcase
		end
		if (wrEn && wstrb[1] && wAddr == OFF_REF_TIMER) begin
			refCount_d[15:8] = wdata[15:8];
		end

		// Hardware sets win over a clear in the same cycle
		if (periodEnd) begin
			flags_d[FLG_PERIOD] = 1'b1;
		end
		if (newMatch) begin
			flags_d[FLG_MATCH] = 1'b1;
		end
		if (refStep && !refReset && refCount_q == 16'hFFFF) begin
			flags_d[FLG_REFOVF] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else begin
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
		end
	end

	always_ff @(posedge clk or negedge rstN_q) begin
		if (!rstN_q) begin
			ctrl_q       <= unit_ctrl_t'(6'h00);
			dutyLow_q    <= RST_BYTE;
			dutyActive_q <= RST_BYTE;
			dutyLatch_q  <= 2'h0;
			period_q     <= RST_PERIOD;
			ptCtrl_q     <= pt_ctrl_t'(7'h00);
			refRun_q     <= 1'b0;
			refCount_q   <= RST_REF;
			flags_q      <= '0;
			matchSeen_q  <= 1'b0;
			pin_q        <= 1'b0;
		end else begin
			ctrl_q       <= ctrl_d;
			dutyLow_q    <= dutyLow_d;
			dutyActive_q <= dutyActive_d;
			dutyLatch_q  <= dutyLatch_d;
			period_q     <= period_d;
			ptCtrl_q     <= ptCtrl_d;
			refRun_q     <= refRun_d;
			refCount_q   <= refCount_d;
			flags_q      <= flags_d;
			matchSeen_q  <= matchSeen_d;
			pin_q        <= pin_d;
		end
	end

endmodule

// ==== adc_pin_load.sv ====
// ADC start input and pulled-down load on the PWM pin
`timescale 1ns/1ps
module adc_pin_load (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// From the unit
	input  wire logic adcStart,
	input  wire logic eventPinOut,
	input  wire logic eventPinDrive,
	// Observed
	output int        startCount,
	output logic      pinLevel
);
	// Undriven pin falls to the pull-down level
	assign pinLevel = eventPinDrive ? eventPinOut : 1'b0;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			startCount <= 0;
		end else if (adcStart) begin
			startCount <= startCount + 1;
		end
	end
endmodule

// ==== ccp_trigger_pwm_monitor.sv ====
// Port checker for the trigger and PWM unit
`timescale 1ns/1ps
module ccp_trigger_pwm_monitor
	import ccp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bus handshakes
	input wire logic awvalid,
	input wire logic wvalid,
	input wire logic awready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	// System and outputs
	input wire logic sleep,
	input wire logic adcEnable,
	input wire logic adcStart,
	input wire logic eventPinOut,
	input wire logic eventPinDrive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_trigGate; adcStart |-> adcEnable; endproperty
	a_trigGate: assert property (p_trigGate) else $error("start off");
	property p_noDrive; adcStart |-> !eventPinDrive; endproperty
	a_noDrive: assert property (p_noDrive) else $error("pin driven");
	property p_onePulse; adcStart |=> !adcStart; endproperty
	a_onePulse: assert property (p_onePulse) else $error("long start");
	property p_sleepTrig; sleep |-> !adcStart; endproperty
	a_sleepTrig: assert property (p_sleepTrig) else $error("asleep");
	property p_sleepPin; sleep [*2] |-> $stable(eventPinOut); endproperty
	a_sleepPin: assert property (p_sleepPin) else $error("pin moved");
	property p_pinIdle;
		!eventPinDrive ##1 !eventPinDrive |-> !eventPinOut;
	endproperty
	a_pinIdle: assert property (p_pinIdle) else $error("idle pin high");
	property p_wrAns; awvalid && wvalid && awready |=> bvalid; endproperty
	a_wrAns: assert property (p_wrAns) else $error("no write answer");
	property p_rdAns; arvalid && arready |=> rvalid; endproperty
	a_rdAns: assert property (p_rdAns) else $error("no read answer");

	c_start: cover property (adcStart);
	c_pinRise: cover property ($rose(eventPinOut));
	c_sleepHigh: cover property (sleep && eventPinOut);
endmodule

bind ccp_compare_trigger_and_pwm ccp_trigger_pwm_monitor u_mon (.clk, .nrst,
	.awvalid, .wvalid, .awready, .bvalid, .arvalid, .arready, .rvalid,
	.sleep, .adcEnable, .adcStart, .eventPinOut, .eventPinDrive);

// ==== tb_ccp_compare_trigger_and_pwm.sv ====
// Self-checking bench for the trigger and PWM unit
`timescale 1ns/1ps
module tb_ccp_compare_trigger_and_pwm
	import ccp_pkg::*;
;
	logic        clk = 0, nrst = 0, sleep = 0, refTick = 0, adcEnable = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [2:0]  awprot = 3'h0, arprot = 3'h0;
	logic [3:0]  wstrb = 4'hF;
	logic [31:0] wdata = 32'h0, rdata, rdv;
	logic [1:0]  bresp, rresp, rsp;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        adcStart, eventPinOut, eventPinDrive, pin;
	int          startCount, errTotal = 0, nChecks = 0;

	always #12.5 clk = ~clk;

	ccp_compare_trigger_and_pwm u_dut (.clk, .nrst, .awaddr, .awprot,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sleep, .refTick, .adcEnable,
		.adcStart, .eventPinOut, .eventPinDrive);
	adc_pin_load u_load (.clk, .nrst, .adcStart, .eventPinOut,
		.eventPinDrive, .startCount, .pinLevel(pin));

	task automatic reportAndStop();
		$display("checks %0d errors %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		nChecks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
			errTotal++;
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge clk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(logic [7:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rdv = rdata;
		rsp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic tick(int n);
		repeat (n) begin
			refTick <= 1'b1;
			@(posedge clk);
			refTick <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask

	task automatic pinHeld(logic e);
		int bad;
		bad = 0;
		repeat (70) begin
			@(posedge clk);
			if (pin !== e) bad++;
		end
		chk("pin held", 32'h0, 32'(bad));
	endtask

	task automatic pwmMeasure(output int hi, output int per);
		hi = 0;
		while (!pin) @(posedge clk);
		while (pin) @(posedge clk);
		while (!pin) @(posedge clk);
		while (pin) begin
			hi++;
			@(posedge clk);
		end
		per = hi;
		while (!pin) begin
			per++;
			@(posedge clk);
		end
	endtask

	task automatic tRegs();
		rd(OFF_PERIOD);
		chk("period reset", 32'hFF, rdv);
		rd(8'hFC);
		chk("unmapped read", 32'(RESP_SLVERR), 32'(rsp));
		wr(8'hFC, 32'h1);
		chk("unmapped write", 32'(RESP_SLVERR), 32'(rsp));
	endtask

	task automatic tTrigger();
		wr(OFF_DUTY_ACTIVE, 32'h0);
		wr(OFF_DUTY_LOW, 32'h5);
		wr(OFF_UNIT_CTRL, 32'(MODE_TRIG));
		wr(OFF_REF_CTRL, 32'h1);
		adcEnable <= 1'b1;
		tick(5);
		chk("adc starts", 32'h1, 32'(startCount));
		chk("pin drive", 32'h0, 32'(eventPinDrive));
		rd(OFF_REF_TIMER);
		chk("no early reset", 32'h5, rdv);
		tick(1);
		rd(OFF_REF_TIMER);
		chk("timer reset", 32'h0, rdv);
		rd(OFF_FLAGS);
		chk("flags", 32'h4, rdv);
		adcEnable <= 1'b0;
		tick(5);
		chk("adc gated", 32'h1, 32'(startCount));
		wr(OFF_DUTY_LOW, 32'h9);
		tick(1);
		rd(OFF_REF_TIMER);
		chk("reset skipped", 32'h6, rdv);
		wr(OFF_UNIT_CTRL, 32'h0);
	endtask

	task automatic tPwm();
		int hi, per, p;
		for (int ps = 0; ps < 4; ps++) begin
			p = 1 << (2 * ps);
			wr(OFF_PT_CTRL, 32'h0);
			wr(OFF_PT_COUNT, 32'h0);
			wr(OFF_PERIOD, 32'h3);
			wr(OFF_UNIT_CTRL, 32'h2C);
			wr(OFF_DUTY_LOW, 32'h1);
			wr(OFF_FLAGS, 32'h7);
			wr(OFF_PT_CTRL, {25'h0, 4'hF, 1'b1, 2'(ps)});
			pwmMeasure(hi, per);
			chk("pwm period", 32'(16 * p), 32'(per));
			chk("pwm high", 32'(6 * p), 32'(hi));
		end
		// Back to 1:4 for the level and sleep scenarios
		wr(OFF_PT_CTRL, 32'h0000_007D);
		wr(OFF_DUTY_ACTIVE, 32'h55);
		rd(OFF_DUTY_ACTIVE);
		chk("active duty", 32'h1, rdv);
	endtask

	task automatic tLevels();
		wr(OFF_DUTY_LOW, 32'hFF);
		repeat (80) @(posedge clk);
		pinHeld(1'b1);
		wr(OFF_UNIT_CTRL, 32'h0C);
		wr(OFF_DUTY_LOW, 32'h0);
		repeat (140) @(posedge clk);
		pinHeld(1'b0);
	endtask

	task automatic tSleep();
		logic [31:0] c0;
		logic        p0;
		wr(OFF_UNIT_CTRL, 32'h2C);
		wr(OFF_DUTY_LOW, 32'h1);
		repeat (100) @(posedge clk);
		sleep <= 1'b1;
		repeat (2) @(posedge clk);
		p0 = pin;
		rd(OFF_PT_COUNT);
		c0 = rdv;
		repeat (50) @(posedge clk);
		rd(OFF_PT_COUNT);
		chk("count frozen", c0, rdv);
		chk("pin frozen", 32'(p0), 32'(pin));
		sleep <= 1'b0;
		repeat (40) @(posedge clk);
		rd(OFF_PT_COUNT);
		chk("count resumes", 32'h1, 32'(rdv != c0));
	endtask

	task automatic tReset();
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("pin after reset", 32'h0, 32'(pin));
		chk("bus idle", 32'h0, 32'({bvalid, rvalid}));
		rd(OFF_PERIOD);
		chk("period after reset", 32'(RST_PERIOD), rdv);
		rd(OFF_FLAGS);
		chk("flags after reset", 32'h0, rdv);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		tRegs();
		tTrigger();
		tPwm();
		tLevels();
		tSleep();
		tReset();
		reportAndStop();
	end

	initial begin
		#(25 * 20000);
		errTotal++;
		reportAndStop();
	end
endmodule
